// ### expanded_ram_address_pointer_unit.sv
`timescale 1ns/1ps
`include "expanded_ram_pointer_regs.svh"
module expanded_ram_address_pointer_unit
    import expanded_ram_pointer_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire sfr_req_s    sfr,
    input  wire ptr_op_e     op,
    input  wire logic        idx_move,
    input  wire logic        idx_write,
    input  wire logic [7:0]  index_register,
    input  wire logic [15:0] imm16,
    input  wire logic [7:0]  acc,
    output logic [7:0]       sfr_rdata_q,
    output expanded_ram_req_s        expanded_ram_q,
    output logic             code_rd_q,
    output logic [15:0]      code_addr_q,
    output logic             jump_q,
    output logic [15:0]      jump_addr_q,
    output logic [15:0]      active_data_pointer_q,
    output logic             pointer_bank_select_q
);
    function automatic logic [15:0] acc_plus(input logic [15:0] p,
                                             input logic [7:0]  a);
        acc_plus = p + {8'h00, a};
    endfunction : acc_plus

    logic [15:0] pointer_zero_q;
    logic [15:0] pointer_one_q;
    logic [1:0]  page_q;
    logic        bank_q;

    wire logic        wr_low   = sfr.wr && sfr.addr == `PTR_LOW_ADDR;
    wire logic        wr_high  = sfr.wr && sfr.addr == `PTR_HIGH_ADDR;
    wire logic        wr_page  = sfr.wr && sfr.addr == `PAGE_SEL_ADDR;
    wire logic        wr_aux   = sfr.wr && sfr.addr == `AUX_CTRL1_ADDR;
    wire logic [15:0] active   = bank_q ? pointer_one_q
                                        : pointer_zero_q; // RQ2 RQ3 RQ17
    wire logic [15:0] ptr_inc  = active + 16'h0001; // RQ4
    wire logic        is_xmove = op == OP_XREAD || op == OP_XWRITE;
    wire logic [15:0] idx_addr = {6'h00, page_q, index_register}; // RQ11 RQ13

    // next value of the active pointer; increment and load take priority over sfr
    logic [15:0] act_d;
    always_comb begin
        act_d = active;
        if (wr_low)
            act_d[7:0] = sfr.wdata; // RQ9 RQ16
        if (wr_high)
            act_d[15:8] = sfr.wdata; // RQ10 RQ16
        if (op == OP_INC)
            act_d = ptr_inc; // RQ4
        else if (op == OP_LOAD)
            act_d = imm16; // RQ5
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pointer_zero_q <= `PTR_RESET;
            pointer_one_q  <= `PTR_RESET;
        end else if (bank_q) begin
            pointer_one_q  <= act_d; // RQ1 RQ16
        end else begin
            pointer_zero_q <= act_d; // RQ1 RQ16
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            page_q <= `PAGE_RESET;
            bank_q <= 1'b0;
        end else begin
            // reserved page bits are not stored, so they read zero
            if (wr_page)
                page_q <= sfr.wdata[`PAGE_LSB +: `PAGE_W]; // RQ13 RQ14
            if (wr_aux)
                bank_q <= sfr.wdata[`BANK_BIT]; // RQ2
        end
    end

    wire logic [7:0] rd_mux =
        sfr.addr == `PTR_LOW_ADDR   ? active[7:0]  :
        sfr.addr == `PTR_HIGH_ADDR  ? active[15:8] :
        sfr.addr == `PAGE_SEL_ADDR  ? {6'h00, page_q} :
        sfr.addr == `AUX_CTRL1_ADDR ? {7'h00, bank_q} : 8'h00;

    // page 3 is outside the 768-byte array; access is dropped, not wrapped
    wire logic [15:0] x_addr = idx_move ? idx_addr : active; // RQ7 RQ11
    wire logic        x_ok   = x_addr <= `EXPANDED_RAM_LAST; // RQ15

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_q           <= 8'h00;
            expanded_ram_q                <= '0;
            code_rd_q             <= 1'b0;
            code_addr_q           <= 16'h0000;
            jump_q                <= 1'b0;
            jump_addr_q           <= 16'h0000;
            active_data_pointer_q <= `PTR_RESET;
            pointer_bank_select_q <= 1'b0;
        end else begin
            if (sfr.rd)
                sfr_rdata_q <= rd_mux;
            expanded_ram_q.valid <= (is_xmove || idx_move) && x_ok; // RQ7 RQ15
            expanded_ram_q.write <= idx_move ? idx_write : op == OP_XWRITE;
            expanded_ram_q.addr  <= x_addr;
            expanded_ram_q.wdata <= acc;
            code_rd_q    <= op == OP_CODE; // RQ6
            code_addr_q  <= acc_plus(active, acc); // RQ6
            jump_q       <= op == OP_JUMP; // RQ8
            jump_addr_q  <= acc_plus(active, acc); // RQ8
            active_data_pointer_q <= bank_q ? pointer_one_q : pointer_zero_q;
            pointer_bank_select_q <= bank_q;
        end
    end

    sequence inc_seen_s;
        op == OP_INC && !bank_q;
    endsequence
    inc_carry_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ4
        inc_seen_s |=> pointer_zero_q == $past(pointer_zero_q) + 16'h0001)
        else $error("increment wrong");
    load_bank_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
        op == OP_LOAD && bank_q |=> pointer_one_q == $past(imm16)
            && pointer_zero_q == $past(pointer_zero_q))
        else $error("load wrong");
    code_addr_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
        op == OP_CODE |=> code_rd_q
            && code_addr_q == $past(active) + {8'h00, $past(acc)})
        else $error("code address wrong");
    xmove_addr_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
        is_xmove && !idx_move && active <= 16'h02ff
            |=> expanded_ram_q.valid && expanded_ram_q.addr == $past(active))
        else $error("expanded_ram address wrong");
    jump_addr_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ8
        op == OP_JUMP |=> jump_q
            && jump_addr_q == $past(active) + {8'h00, $past(acc)})
        else $error("jump address wrong");
    idx_page_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ11
        idx_move && page_q != 2'h3 |=> expanded_ram_q.valid
            && expanded_ram_q.addr == {6'h00, $past(page_q), $past(index_register)})
        else $error("indexed address wrong");
    low_steer_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ16
        wr_low && op == OP_NONE && bank_q |=> pointer_one_q[7:0]
            == $past(sfr.wdata) && pointer_zero_q == $past(pointer_zero_q))
        else $error("low byte steering wrong");
    bank_next_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ17
        wr_aux && op == OP_NONE ##1 op == OP_JUMP
            |=> jump_addr_q == ($past(bank_q) ? $past(pointer_one_q)
                : $past(pointer_zero_q)) + {8'h00, $past(acc)})
        else $error("bank switch late");
    page_range_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ15
        expanded_ram_q.valid |-> expanded_ram_q.addr <= 16'h02ff)
        else $error("expanded_ram out of range");

    // the idle pointer must never move, whatever the active one does
    zero_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
        bank_q |=> pointer_zero_q == $past(pointer_zero_q))
        else $error("pointer zero moved while idle");

    one_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
        !bank_q |=> pointer_one_q == $past(pointer_one_q))
        else $error("pointer one moved while idle");

    view_out_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
        1'b1 |=> active_data_pointer_q == $past(active))
        else $error("pointer view wrong");

    bank_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
        wr_aux |=> bank_q == $past(sfr.wdata[0]))
        else $error("bank select not stored");

    bank_out_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
        1'b1 |=> pointer_bank_select_q == $past(bank_q))
        else $error("bank select output wrong");

    inc_one_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ4
        op == OP_INC && bank_q
            |=> pointer_one_q == $past(pointer_one_q) + 16'h0001)
        else $error("increment of pointer one wrong");

    load_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
        op == OP_LOAD && !bank_q |=> pointer_zero_q == $past(imm16)
            && pointer_one_q == $past(pointer_one_q))
        else $error("load of pointer zero wrong");

    // a load beats a low byte register write to the same pointer
    load_wins_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
        op == OP_LOAD && wr_low && !bank_q
            |=> pointer_zero_q == $past(imm16))
        else $error("load lost to register write");

    low_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
        wr_low && !wr_high && op == OP_NONE && !bank_q
            |=> pointer_zero_q[7:0] == $past(sfr.wdata)
            && pointer_zero_q[15:8] == $past(pointer_zero_q[15:8]))
        else $error("low byte write wrong");

    high_one_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ10
        wr_high && !wr_low && op == OP_NONE && bank_q
            |=> pointer_one_q[15:8] == $past(sfr.wdata)
            && pointer_one_q[7:0] == $past(pointer_one_q[7:0]))
        else $error("high byte write wrong");

    high_steer_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ16
        wr_high && op == OP_NONE && !bank_q
            |=> pointer_zero_q[15:8] == $past(sfr.wdata)
            && pointer_one_q == $past(pointer_one_q))
        else $error("high byte steering wrong");

    rd_low_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
        sfr.rd && sfr.addr == `PTR_LOW_ADDR
            |=> sfr_rdata_q == $past(active[7:0]))
        else $error("low byte read wrong");

    rd_high_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ10
        sfr.rd && sfr.addr == `PTR_HIGH_ADDR
            |=> sfr_rdata_q == $past(active[15:8]))
        else $error("high byte read wrong");

    rd_page_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ13
        sfr.rd && sfr.addr == `PAGE_SEL_ADDR
            |=> sfr_rdata_q == {6'h00, $past(page_q)})
        else $error("page read wrong");

    rd_bank_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
        sfr.rd && sfr.addr == `AUX_CTRL1_ADDR
            |=> sfr_rdata_q == {7'h00, $past(bank_q)})
        else $error("bank read wrong");

    rd_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ9
        !sfr.rd |=> $stable(sfr_rdata_q))
        else $error("read data changed without read");

    page_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ14
        wr_page |=> page_q == $past(sfr.wdata[1:0]))
        else $error("page not stored");

    code_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ6
        op != OP_CODE |=> !code_rd_q)
        else $error("stray code read");

    jump_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ8
        op != OP_JUMP |=> !jump_q)
        else $error("stray jump");

    xwrite_kind_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
        op == OP_XWRITE && !idx_move && active <= `EXPANDED_RAM_LAST
            |=> expanded_ram_q.write && expanded_ram_q.wdata == $past(acc))
        else $error("expanded_ram write wrong");

    xread_kind_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
        op == OP_XREAD && !idx_move && active <= `EXPANDED_RAM_LAST
            |=> !expanded_ram_q.write)
        else $error("expanded_ram read marked as write");

    idle_valid_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
        !is_xmove && !idx_move |=> !expanded_ram_q.valid)
        else $error("stray expanded_ram access");

    idx_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ11
        idx_move && page_q != 2'h3 |=> expanded_ram_q.write == $past(idx_write))
        else $error("indexed direction wrong");

    idx_upper_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ13
        idx_move |=> expanded_ram_q.addr[15:10] == 6'h00)
        else $error("indexed upper bits not zero");

    page3_drop_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ14
        idx_move && page_q == 2'h3 |=> !expanded_ram_q.valid)
        else $error("page three not dropped");

    high_drop_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ15
        is_xmove && !idx_move && active > `EXPANDED_RAM_LAST |=> !expanded_ram_q.valid)
        else $error("out of range access not dropped");

    sequence bank_one_s;
        wr_aux && sfr.wdata[0] && op == OP_NONE;
    endsequence
    sequence code_next_s;
        op == OP_CODE;
    endsequence
    bank_code_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ17
        bank_one_s ##1 code_next_s |=> code_addr_q
            == $past(pointer_one_q) + {8'h00, $past(acc)})
        else $error("code read used old bank");

    inc_keep_a: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
        op == OP_INC && !bank_q |=> pointer_one_q == $past(pointer_one_q))
        else $error("increment touched idle pointer");
endmodule : expanded_ram_address_pointer_unit

// ### expanded_ram_pointer_regs.svh
// What this block does
// RQ1 - two independent 16-bit data pointers; only one active at a time
// RQ2 - bank select 0 picks pointer zero, 1 picks pointer one
// RQ3 - all six pointer instructions act on the currently selected pointer
// RQ4 - pointer increment adds one across all 16 bits with carry
// RQ5 - immediate load writes 16-bit constant into active pointer only
// RQ6 - code read address is accumulator plus active pointer
// RQ7 - external read and write use active pointer as 16-bit address
// RQ8 - indirect jump target is accumulator plus active pointer
// RQ9 - low byte register maps active pointer bits 7..0, resets zero
// RQ10 - high byte register maps active pointer bits 15..8, resets zero
// RQ11 - 8-bit indexed move address is page register high, index low
// RQ12 - software writes zero into page register bits 7..2
// RQ13 - page register bits 7..2 always hold zero
// RQ14 - two-bit page field selects one of three 256-byte pages
// RQ15 - expanded ram spans 768 bytes, 0000h to 02ffh
// RQ16 - byte register accesses steer to selected pointer; other keeps value
// RQ17 - bank select change applies to next pointer instruction
`ifndef EXPANDED_RAM_POINTER_REGS_SVH
`define EXPANDED_RAM_POINTER_REGS_SVH
`define PTR_LOW_ADDR     8'h82
`define PTR_HIGH_ADDR    8'h83
`define PAGE_SEL_ADDR    8'h8f
`define AUX_CTRL1_ADDR   8'ha2
`define PTR_RESET        16'h0000
`define PAGE_RESET       2'h0
`define BANK_BIT         0
`define PAGE_LSB         0
`define PAGE_W           2
`define EXPANDED_RAM_LAST        16'h02ff
`endif

// ### expanded_ram_pointer_pkg.sv
package expanded_ram_pointer_pkg;
    typedef enum logic [6:0] {
        OP_NONE   = 7'h01,
        OP_INC    = 7'h02,
        OP_LOAD   = 7'h04,
        OP_CODE   = 7'h08,
        OP_XREAD  = 7'h10,
        OP_XWRITE = 7'h20,
        OP_JUMP   = 7'h40
    } ptr_op_e;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_s;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } expanded_ram_req_s;
endpackage : expanded_ram_pointer_pkg

// ### expanded_ram_model.sv
`timescale 1ns/1ps
module expanded_ram_model
    import expanded_ram_pointer_pkg::*;
(
    input wire logic      mclk,
    input wire expanded_ram_req_s expanded_ram
);
    // only 768 bytes exist; stores above them are dropped, not wrapped
    logic [7:0] mem [0:767];
    always @(posedge mclk) begin
        if (expanded_ram.valid && expanded_ram.write && expanded_ram.addr <= 16'h02ff) begin
            mem[expanded_ram.addr[9:0]] <= expanded_ram.wdata;
        end
    end
endmodule : expanded_ram_model

// ### expanded_ram_address_pointer_unit_tb.sv
`timescale 1ns/1ps
module expanded_ram_address_pointer_unit_tb;
    import expanded_ram_pointer_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0, idx_move = 1'b0, idx_write = 1'b0;
    sfr_req_s    sfr = '0;
    ptr_op_e     op = OP_NONE;
    logic [7:0]  index_register = 8'h00, acc = 8'h00, sfr_rdata_q;
    logic [15:0] imm16 = 16'h0000, code_addr_q, jump_addr_q, adp_q, p0, p1;
    logic        code_rd_q, jump_q, bank_q, rd_p = 1'b0;
    expanded_ram_req_s   expanded_ram_q;
    logic [15:0] expq [$];
    int          error_cnt = 0, checks = 0;
    always #12.5 mclk = ~mclk;
    expanded_ram_address_pointer_unit expanded_ram_address_pointer_unit_inst (
        .mclk(mclk), .rst_n(rst_n), .sfr(sfr), .op(op), .idx_move(idx_move),
        .idx_write(idx_write), .index_register(index_register),
        .imm16(imm16), .acc(acc), .sfr_rdata_q(sfr_rdata_q), .expanded_ram_q(expanded_ram_q),
        .code_rd_q(code_rd_q), .code_addr_q(code_addr_q), .jump_q(jump_q),
        .jump_addr_q(jump_addr_q), .active_data_pointer_q(adp_q),
        .pointer_bank_select_q(bank_q));
    expanded_ram_model expanded_ram_model_inst (.mclk(mclk), .expanded_ram(expanded_ram_q));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task sacc(input logic w, input logic r, input logic [7:0] a,
              input logic [7:0] d);
        sfr = '{w, r, a, d};
        @(negedge mclk);
        sfr = '0;
    endtask : sacc
    task dop(input ptr_op_e o, input logic [15:0] e);
        if (o != OP_INC && o != OP_LOAD)
            expq.push_back(e);
        op = o;
        @(negedge mclk);
        op = OP_NONE;
    endtask : dop
    task end_of_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // results arrive one cycle after the taking edge, so old values are read
    always @(posedge mclk) begin
        if (rd_p)
            chk({8'h00, sfr_rdata_q}, expq.pop_front());
        if (expanded_ram_q.valid)
            chk(expanded_ram_q.addr, expq.pop_front());
        if (code_rd_q)
            chk(code_addr_q, expq.pop_front());
        if (jump_q)
            chk(jump_addr_q, expq.pop_front());
        rd_p <= sfr.rd;
    end
    initial begin
        #(3000 * 25);
        error_cnt++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'h69b8));
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        expq.push_back(16'h0000);
        sacc(1'b0, 1'b1, 8'h82, 8'h00);
        expq.push_back(16'h0000);
        sacc(1'b0, 1'b1, 8'h83, 8'h00);
        $display("test reset done");
        p0 = 16'($urandom) & 16'h01ff;
        p1 = (16'($urandom) & 16'h00ff) | 16'h0200;
        imm16 = p0;
        dop(OP_LOAD, 16'h0000);
        sacc(1'b1, 1'b0, 8'ha2, 8'h01);
        imm16 = p1;
        dop(OP_LOAD, 16'h0000);
        @(negedge mclk);
        chk(adp_q, p1);
        expq.push_back({8'h00, p1[7:0]});
        sacc(1'b0, 1'b1, 8'h82, 8'h00);
        dop(OP_XREAD, p1);
        sacc(1'b1, 1'b0, 8'ha2, 8'h00);
        dop(OP_XREAD, p0);
        chk({15'h0000, bank_q}, 16'h0000);
        sacc(1'b1, 1'b0, 8'h82, 8'hff);
        sacc(1'b1, 1'b0, 8'h83, 8'h00);
        dop(OP_INC, 16'h0000);
        dop(OP_XREAD, 16'h0100);
        sacc(1'b1, 1'b0, 8'ha2, 8'h01);
        acc = 8'($urandom);
        dop(OP_CODE, p1 + {8'h00, acc});
        dop(OP_JUMP, p1 + {8'h00, acc});
        dop(OP_XWRITE, p1);
        @(negedge mclk);
        chk({8'h00, expanded_ram_model_inst.mem[p1[9:0]]}, {8'h00, acc});
        $display("test pointers done");
        sacc(1'b1, 1'b0, 8'h8f, 8'h03);
        expq.push_back(16'h0003);
        sacc(1'b0, 1'b1, 8'h8f, 8'h00);
        for (int pg = 0; pg < 4; pg++) begin
            sacc(1'b1, 1'b0, 8'h8f, 8'(pg));
            index_register = 8'($urandom);
            idx_write = 1'($urandom);
            if (pg < 3)
                expq.push_back({6'h00, pg[1:0], index_register});
            idx_move = 1'b1;
            @(negedge mclk);
            idx_move = 1'b0;
        end
        repeat (3) @(negedge mclk);
        chk(16'(expq.size()), 16'h0000);
        $display("test pages done");
        end_of_test;
    end
endmodule : expanded_ram_address_pointer_unit_tb
